// File: hdl/bbn_unit.v
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "bbn_consts.vh"

module bbn_unit #(
  parameter ADDR_W = 8,
  parameter WORD_W = 16
) (
  CLK,
  RST,
  ADDR,
  WDATA,
  WR,
  RD,
  RDATA,
  OP,
  SRC_LO,
  SRC_HI,
  EXEC,
  ONCE,
  RES_LO,
  RES_HI,
  RES_WR,
  RES_DBL,
  FAULT_FLAG,
  ZERO_FLAG,
  POLARITY_FLAG,
  DONE,
  BUSY,
  IRQ
);

  input  wire                  CLK;
  input  wire                  RST;
  input  wire [ADDR_W-1:0]     ADDR;
  input  wire [31:0]           WDATA;
  input  wire                  WR;
  input  wire                  RD;
  output reg  [31:0]           RDATA;
  input  wire [`BBN_OP_W-1:0]  OP;
  input  wire [WORD_W-1:0]     SRC_LO;
  input  wire [WORD_W-1:0]     SRC_HI;
  input  wire                  EXEC;
  input  wire                  ONCE;
  output reg  [WORD_W-1:0]     RES_LO;
  output reg  [WORD_W-1:0]     RES_HI;
  output reg                   RES_WR;
  output reg                   RES_DBL;
  output reg                   FAULT_FLAG;
  output reg                   ZERO_FLAG;
  output reg                   POLARITY_FLAG;
  output reg                   DONE;
  output reg                   BUSY;
  output reg                   IRQ;

  localparam DW = 2 * WORD_W;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_FIN  = 2'h2;

  reg  [1:0]            state_q;
  reg  [1:0]            state_d;
  reg  [`BBN_OP_W-1:0]  op_q;
  reg  [DW-1:0]         src_q;
  reg  [DW-1:0]         sh_q;
  reg  [DW-1:0]         acc_q;
  reg  [DW-1:0]         bcd_q;
  reg  [`BBN_CNT_W-1:0] cnt_q;
  reg                   flt_q;
  reg                   exec_prev_q;
  reg                   en_q;
  reg  [`BBN_ST_W-1:0]  stat_q;
  reg  [`BBN_ST_W-1:0]  mask_q;
  reg  [31:0]           count_q;

  wire [DW-1:0]         bcd_nx;
  wire [DW-1:0]         acc_nx;
  wire [DW/4-1:0]       bad;
  wire                  op_dbl;
  wire                  op_known;
  wire                  trig;
  wire                  start;
  wire [DW-1:0]         src_in;
  reg                   flt_in;
  reg  [`BBN_CNT_W-1:0] steps_in;
  reg  [DW-1:0]         sh_in;
  reg  [DW-1:0]         res;
  reg                   fin_set;
  reg  [`BBN_ST_W-1:0]  ev;
  reg  [31:0]           rd_mux;

  assign op_dbl   = (OP == `BBN_OP_D2P_D) || (OP == `BBN_OP_P2D_D) || (OP == `BBN_OP_TWC_D);
  assign op_known = (OP <= `BBN_OP_TWC_D);
  // Single-word operations see a zero upper word so checks and sums stay 16 bit
  assign src_in   = op_dbl ? {SRC_HI, SRC_LO} : {{WORD_W{1'b0}}, SRC_LO};

  // Prefixed form needs a low-to-high change seen while idle; an edge that
  // lands while busy is not remembered
  assign trig  = ONCE ? (EXEC & ~exec_prev_q) : EXEC;
  assign start = (state_q == ST_IDLE) && trig && en_q && op_known;

  bbn_dec_step #(
    .DIGITS (DW/4)
  ) u_step (
    .bcd_in    (bcd_q),
    .bit_in    (sh_q[DW-1]),
    .acc_in    (acc_q),
    .digit_in  (sh_q[DW-1:DW-4]),
    .chk_in    (src_in),
    .bcd_out   (bcd_nx),
    .acc_out   (acc_nx),
    .digit_bad (bad)
  );

  // Fault check and iteration setup at the start of an operation
  always @* begin
    flt_in   = 1'b0;
    steps_in = `BBN_STEPS_D2P_S;
    sh_in    = src_in;
    case (OP)
      `BBN_OP_D2P_S: begin
        flt_in   = |bad;
        steps_in = `BBN_STEPS_D2P_S;
        sh_in    = {src_in[WORD_W-1:0], {WORD_W{1'b0}}};
      end
      `BBN_OP_D2P_D: begin
        flt_in   = |bad;
        steps_in = `BBN_STEPS_D2P_D;
      end
      `BBN_OP_P2D_S: begin
        flt_in   = src_in[WORD_W-1:0] > `BBN_BCD_MAX_S;
        steps_in = `BBN_STEPS_P2D_S;
        sh_in    = {src_in[WORD_W-1:0], {WORD_W{1'b0}}};
      end
      `BBN_OP_P2D_D: begin
        flt_in   = src_in > `BBN_BCD_MAX_D;
        steps_in = `BBN_STEPS_P2D_D;
      end
      default: begin
        flt_in = 1'b0;
      end
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          if (flt_in || (OP >= `BBN_OP_TWC_S)) begin
            state_d = ST_FIN;
          end else begin
            state_d = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        if (cnt_q == {{(`BBN_CNT_W-1){1'b0}}, 1'b1}) begin
          state_d = ST_FIN;
        end
      end
      ST_FIN: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Result of the finished operation
  always @* begin
    res = acc_q;
    case (op_q)
      `BBN_OP_D2P_S: res = acc_q;
      `BBN_OP_D2P_D: res = acc_q;
      `BBN_OP_P2D_S: res = bcd_q;
      `BBN_OP_P2D_D: res = bcd_q;
      // Wraps naturally, so 8000 hex negates to itself
      `BBN_OP_TWC_S: res = {{WORD_W{1'b0}}, ~src_q[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, 1'b1}};
      `BBN_OP_TWC_D: res = ~src_q + {{(DW-1){1'b0}}, 1'b1};
      default:       res = acc_q;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_q     <= ST_IDLE;
      op_q        <= `BBN_OP_D2P_S;
      src_q       <= {DW{1'b0}};
      sh_q        <= {DW{1'b0}};
      acc_q       <= {DW{1'b0}};
      bcd_q       <= {DW{1'b0}};
      cnt_q       <= {`BBN_CNT_W{1'b0}};
      flt_q       <= 1'b0;
      exec_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      exec_prev_q <= EXEC;
      if (start) begin
        op_q  <= OP;
        src_q <= src_in;
        sh_q  <= sh_in;
        acc_q <= {DW{1'b0}};
        bcd_q <= {DW{1'b0}};
        cnt_q <= steps_in;
        flt_q <= flt_in;
      end else if (state_q == ST_CONV) begin
        cnt_q <= cnt_q - {{(`BBN_CNT_W-1){1'b0}}, 1'b1};
        if ((op_q == `BBN_OP_D2P_S) || (op_q == `BBN_OP_D2P_D)) begin
          acc_q <= acc_nx;
          sh_q  <= {sh_q[DW-5:0], 4'h0};
        end else begin
          bcd_q <= bcd_nx;
          sh_q  <= {sh_q[DW-2:0], 1'b0};
        end
      end
    end
  end

  // Operation outputs; everything leaves from a flop
  always @(posedge CLK) begin
    if (RST) begin
      RES_LO        <= {WORD_W{1'b0}};
      RES_HI        <= {WORD_W{1'b0}};
      RES_WR        <= 1'b0;
      RES_DBL       <= 1'b0;
      FAULT_FLAG    <= 1'b0;
      ZERO_FLAG     <= 1'b0;
      POLARITY_FLAG <= 1'b0;
      DONE          <= 1'b0;
      BUSY          <= 1'b0;
    end else begin
      RES_WR <= 1'b0;
      DONE   <= 1'b0;
      BUSY   <= (state_d != ST_IDLE);
      if (state_q == ST_FIN) begin
        DONE       <= 1'b1;
        FAULT_FLAG <= flt_q;
        if (!flt_q) begin
          // A faulting conversion writes nothing and keeps the old words
          RES_WR  <= 1'b1;
          RES_DBL <= (op_q == `BBN_OP_D2P_D) || (op_q == `BBN_OP_P2D_D) || (op_q == `BBN_OP_TWC_D);
          RES_LO  <= res[WORD_W-1:0];
          RES_HI  <= res[DW-1:WORD_W];
          case (op_q)
            `BBN_OP_TWC_S: begin
              ZERO_FLAG     <= (res[WORD_W-1:0] == {WORD_W{1'b0}});
              POLARITY_FLAG <= res[WORD_W-1];
            end
            `BBN_OP_TWC_D: begin
              ZERO_FLAG     <= (res == {DW{1'b0}});
              POLARITY_FLAG <= res[DW-1];
            end
            `BBN_OP_D2P_D, `BBN_OP_P2D_D: begin
              ZERO_FLAG     <= (res == {DW{1'b0}});
              POLARITY_FLAG <= 1'b0;
            end
            default: begin
              ZERO_FLAG     <= (res[WORD_W-1:0] == {WORD_W{1'b0}});
              POLARITY_FLAG <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Interrupt events, registers and read path
  always @* begin
    ev                = {`BBN_ST_W{1'b0}};
    ev[`BBN_ST_DONE]  = (state_q == ST_FIN);
    ev[`BBN_ST_FAULT] = (state_q == ST_FIN) && flt_q;
    fin_set           = (state_q == ST_FIN);
  end

  always @* begin
    rd_mux = 32'h0;
    case (ADDR)
      `BBN_REG_CTRL: begin
        rd_mux[`BBN_CTRL_EN] = en_q;
      end
      `BBN_REG_FLAGS: begin
        rd_mux[`BBN_FL_FAULT] = FAULT_FLAG;
        rd_mux[`BBN_FL_ZERO]  = ZERO_FLAG;
        rd_mux[`BBN_FL_POL]   = POLARITY_FLAG;
        rd_mux[`BBN_FL_BUSY]  = BUSY;
      end
      `BBN_REG_STAT: begin
        rd_mux[`BBN_ST_W-1:0] = stat_q;
      end
      `BBN_REG_MASK: begin
        rd_mux[`BBN_ST_W-1:0] = mask_q;
      end
      `BBN_REG_RESULT: begin
        rd_mux = {RES_HI, RES_LO};
      end
      `BBN_REG_COUNT: begin
        rd_mux = count_q;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      en_q    <= `BBN_CTRL_RST;
      mask_q  <= `BBN_MASK_RST;
      stat_q  <= {`BBN_ST_W{1'b0}};
      count_q <= 32'h0;
      RDATA   <= 32'h0;
      IRQ     <= 1'b0;
    end else begin
      if (WR && (ADDR == `BBN_REG_CTRL)) begin
        en_q <= WDATA[`BBN_CTRL_EN];
      end
      if (WR && (ADDR == `BBN_REG_MASK)) begin
        mask_q <= WDATA[`BBN_ST_W-1:0];
      end
      // A new event in the cycle of the clearing read survives it
      if (RD && (ADDR == `BBN_REG_STAT)) begin
        stat_q <= ev;
      end else begin
        stat_q <= stat_q | ev;
      end
      if (fin_set) begin
        count_q <= count_q + 32'h1;
      end
      RDATA <= RD ? rd_mux : 32'h0;
      IRQ   <= |(stat_q & mask_q);
    end
  end

endmodule

// File: hdl/bbn_consts.vh
`ifndef BBN_CONSTS_VH
`define BBN_CONSTS_VH

// Operation codes on OP
`define BBN_OP_W            3
`define BBN_OP_D2P_S        3'h0
`define BBN_OP_D2P_D        3'h1
`define BBN_OP_P2D_S        3'h2
`define BBN_OP_P2D_D        3'h3
`define BBN_OP_TWC_S        3'h4
`define BBN_OP_TWC_D        3'h5

// Register byte offsets
`define BBN_REG_CTRL        8'h00
`define BBN_REG_FLAGS       8'h04
`define BBN_REG_STAT        8'h08
`define BBN_REG_MASK        8'h0c
`define BBN_REG_RESULT      8'h10
`define BBN_REG_COUNT       8'h14

// Field positions and reset values
`define BBN_CTRL_EN         0
`define BBN_CTRL_RST        1'b1
`define BBN_FL_FAULT        0
`define BBN_FL_ZERO         1
`define BBN_FL_POL          2
`define BBN_FL_BUSY         3
`define BBN_ST_DONE         0
`define BBN_ST_FAULT        1
`define BBN_ST_W            2
`define BBN_MASK_RST        2'h0

// Range limits of plain-to-decimal conversion
`define BBN_BCD_MAX_S       16'h270f
`define BBN_BCD_MAX_D       32'h05f5e0ff

// Iteration counts
`define BBN_CNT_W           6
`define BBN_STEPS_D2P_S     6'd4
`define BBN_STEPS_D2P_D     6'd8
`define BBN_STEPS_P2D_S     6'd16
`define BBN_STEPS_P2D_D     6'd32

// Digit arithmetic
`define BBN_DIGIT_MAX       4'h9
`define BBN_DABBLE_LIM      4'h5
`define BBN_DABBLE_ADD      4'h3

`endif

// File: hdl/bbn_dec_step.v
`timescale 1ns/100ps
`include "bbn_consts.vh"

// One iteration of both conversion directions plus a digit validity check.
module bbn_dec_step #(
  parameter DIGITS = 8
) (
  input  wire [4*DIGITS-1:0] bcd_in,
  input  wire                bit_in,
  input  wire [4*DIGITS-1:0] acc_in,
  input  wire [3:0]          digit_in,
  input  wire [4*DIGITS-1:0] chk_in,
  output wire [4*DIGITS-1:0] bcd_out,
  output wire [4*DIGITS-1:0] acc_out,
  output wire [DIGITS-1:0]   digit_bad
);

  wire [4*DIGITS-1:0] adj;

  genvar i;
  generate
    for (i = 0; i < DIGITS; i = i + 1) begin : g_dig
      wire [3:0] d;
      assign d = bcd_in[4*i+3:4*i];
      // Add three before the shift so a digit of five or more carries out
      assign adj[4*i+3:4*i] = (d >= `BBN_DABBLE_LIM) ? (d + `BBN_DABBLE_ADD) : d;
      assign digit_bad[i]   = chk_in[4*i+3:4*i] > `BBN_DIGIT_MAX;
    end
  endgenerate

  assign bcd_out = {adj[4*DIGITS-2:0], bit_in};
  // Times ten is two shifts and an add; with valid digits the value never exceeds 99999999
  assign acc_out = {acc_in[4*DIGITS-4:0], 3'h0} + {acc_in[4*DIGITS-2:0], 1'h0} +
                   {{(4*DIGITS-4){1'b0}}, digit_in};

endmodule

// File: sim/bbn_seq_model.sv
`timescale 1ns/100ps

// Operand memory of the sequencer: keeps only the result words it is told to write
module bbn_seq_model (
  input  wire        clk,
  input  wire        rst,
  input  wire        res_wr,
  input  wire        res_dbl,
  input  wire [15:0] res_lo,
  input  wire [15:0] res_hi,
  output reg  [15:0] mem_lo,
  output reg  [15:0] mem_hi,
  output reg  [7:0]  wr_cnt
);
  always @(posedge clk) begin
    if (rst) begin
      mem_lo <= 16'h0;
      mem_hi <= 16'h0;
      wr_cnt <= 8'h0;
    end else if (res_wr) begin
      mem_lo <= res_lo;
      if (res_dbl) begin
        mem_hi <= res_hi;
      end
      wr_cnt <= wr_cnt + 8'h1;
    end
  end
endmodule

// File: sim/bbn_unit_assertions.sv
`timescale 1ns/100ps
`include "bbn_consts.vh"

module bbn_unit_assertions (
  input wire                 CLK,
  input wire                 RST,
  input wire [`BBN_OP_W-1:0] OP,
  input wire [15:0]          SRC_LO,
  input wire [15:0]          SRC_HI,
  input wire [15:0]          RES_LO,
  input wire [15:0]          RES_HI,
  input wire                 RES_WR,
  input wire                 RES_DBL,
  input wire                 FAULT_FLAG,
  input wire                 ZERO_FLAG,
  input wire                 POLARITY_FLAG,
  input wire                 DONE,
  input wire                 BUSY
);
  reg  [2:0]  p_op;
  reg  [2:0]  op_q;
  reg  [31:0] p_src;
  reg  [31:0] src_q;
  reg         busy_d;
  wire [31:0] res = {RES_HI, RES_LO};
  wire [31:0] cmpl = ~src_q + 32'h1;
  wire        sng = !op_q[0];

  // Operands are latched when BUSY rises, since the start edge itself is not visible
  always @(posedge CLK) begin
    p_op   <= OP;
    p_src  <= {SRC_HI, SRC_LO};
    busy_d <= BUSY;
    if (BUSY && !busy_d) begin
      op_q  <= p_op;
      src_q <= p_src;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_conv4;
    BUSY [*5] ##1 DONE;
  endsequence
  sequence s_quick_fault;
    ##1 (DONE && FAULT_FLAG);
  endsequence

  AST_TWC_S: assert property (RES_WR && op_q == `BBN_OP_TWC_S |->
    RES_LO == cmpl[15:0] && POLARITY_FLAG == RES_LO[15] && !FAULT_FLAG) else $error("single negate wrong");
  AST_TWC_D: assert property (RES_WR && op_q == `BBN_OP_TWC_D |->
    res == cmpl && POLARITY_FLAG == RES_HI[15] && !FAULT_FLAG) else $error("double negate wrong");
  AST_RANGE_S: assert property (DONE && op_q == `BBN_OP_P2D_S |->
    FAULT_FLAG == (src_q[15:0] > `BBN_BCD_MAX_S)) else $error("single range fault wrong");
  AST_RANGE_D: assert property (DONE && op_q == `BBN_OP_P2D_D |->
    FAULT_FLAG == (src_q > `BBN_BCD_MAX_D)) else $error("double range fault wrong");
  AST_ZERO_S: assert property (RES_WR && sng |->
    ZERO_FLAG == (RES_LO == 16'h0) && !RES_DBL && RES_HI == 16'h0) else $error("single zero flag wrong");
  AST_ZERO_D: assert property (RES_WR && !sng |-> ZERO_FLAG == (res == 32'h0) && RES_DBL)
    else $error("double zero flag wrong");
  AST_NO_PART: assert property (DONE && FAULT_FLAG |-> !RES_WR && $stable(res))
    else $error("result written on fault");
  AST_D2P_LAT: assert property ($rose(BUSY) && p_op == `BBN_OP_D2P_S |-> s_conv4 or s_quick_fault)
    else $error("single decimal conversion timing wrong");
  AST_TWC_LAT: assert property ($rose(BUSY) && p_op == `BBN_OP_TWC_S |=> DONE && RES_WR)
    else $error("single negate timing wrong");
endmodule

bind bbn_unit bbn_unit_assertions u_chk (.CLK(CLK), .RST(RST), .OP(OP), .SRC_LO(SRC_LO), .SRC_HI(SRC_HI),
  .RES_LO(RES_LO), .RES_HI(RES_HI), .RES_WR(RES_WR), .RES_DBL(RES_DBL), .FAULT_FLAG(FAULT_FLAG),
  .ZERO_FLAG(ZERO_FLAG), .POLARITY_FLAG(POLARITY_FLAG), .DONE(DONE), .BUSY(BUSY));

// File: sim/tb_bcd_binary_negate_unit.sv
`timescale 1ns/100ps
`include "bbn_consts.vh"

module tb_bcd_binary_negate_unit;
  reg         CLK = 1'b0;
  reg         RST = 1'b1;
  reg  [7:0]  ADDR = 8'h0;
  reg  [31:0] WDATA = 32'h0;
  reg         WR = 1'b0;
  reg         RD = 1'b0;
  reg  [2:0]  OP = 3'h0;
  reg  [15:0] SRC_LO = 16'h0;
  reg  [15:0] SRC_HI = 16'h0;
  reg         EXEC = 1'b0;
  reg         ONCE = 1'b0;
  wire [31:0] RDATA;
  wire [15:0] RES_LO, RES_HI, mem_lo, mem_hi;
  wire        RES_WR, RES_DBL, FAULT_FLAG, ZERO_FLAG, POLARITY_FLAG, DONE, BUSY, IRQ;
  wire [7:0]  wr_cnt;
  reg  [31:0] last = 32'h0;
  reg  [31:0] d;
  reg  [7:0]  c;
  integer     err_count = 0;
  integer     total_checks = 0;

  always #4 CLK = ~CLK;

  bbn_unit DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OP(OP),
    .SRC_LO(SRC_LO), .SRC_HI(SRC_HI), .EXEC(EXEC), .ONCE(ONCE), .RES_LO(RES_LO), .RES_HI(RES_HI),
    .RES_WR(RES_WR), .RES_DBL(RES_DBL), .FAULT_FLAG(FAULT_FLAG), .ZERO_FLAG(ZERO_FLAG),
    .POLARITY_FLAG(POLARITY_FLAG), .DONE(DONE), .BUSY(BUSY), .IRQ(IRQ));
  bbn_seq_model u_mem (.clk(CLK), .rst(RST), .res_wr(RES_WR), .res_dbl(RES_DBL), .res_lo(RES_LO),
    .res_hi(RES_HI), .mem_lo(mem_lo), .mem_hi(mem_hi), .wr_cnt(wr_cnt));

  task final_report;
    begin
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // Returns {fault, result}; digits packed from the lowest nibble upward
  function [32:0] model(input [2:0] op, input [31:0] s);
    reg [31:0] v, n;
    reg        f;
    integer    i;
    begin
      v = 32'h0;
      f = 1'b0;
      n = op[0] ? s : {16'h0, s[15:0]};
      if (op <= 3'h1) begin
        for (i = op[0] ? 7 : 3; i >= 0; i = i - 1) begin
          if (n[4*i+:4] > 4'h9) f = 1'b1;
          v = v * 32'ha + n[4*i+:4];
        end
      end else if (op <= 3'h3) begin
        f = op[0] ? (n > 32'h05f5e0ff) : (n > 32'h270f);
        for (i = 0; i < 8; i = i + 1) begin
          v[4*i+:4] = n % 32'ha;
          n = n / 32'ha;
        end
      end else begin
        v = ~n + 32'h1;
        if (!op[0]) v[31:16] = 16'h0;
      end
      model = {f, v};
    end
  endfunction

  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge CLK);
      WR <= 1'b1; ADDR <= a; WDATA <= v;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge CLK);
      RD <= 1'b1; ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1 v = RDATA;
    end
  endtask

  // Sources are memory words here; an immediate would only ever feed the single negate
  task run(input [2:0] op, input [31:0] s);
    reg [32:0] e;
    integer    n;
    begin
      e = model(op, s);
      @(posedge CLK);
      OP <= op; SRC_LO <= s[15:0]; SRC_HI <= s[31:16]; EXEC <= 1'b1;
      @(posedge CLK);
      EXEC <= 1'b0;
      #1 n = 0;
      while (DONE !== 1'b1 && n < 60) begin
        @(posedge CLK);
        #1 n = n + 1;
      end
      // Negates and faults finish one cycle after BUSY; conversions take one step per digit or bit
      chk(n, (e[32] || op[2]) ? 32'h1 : (32'h4 << op[1:0]) + 32'h1);
      chk(FAULT_FLAG, e[32]);
      if (!e[32]) begin
        chk(ZERO_FLAG, e[31:0] == 32'h0);
        chk(POLARITY_FLAG, op == 3'h4 ? e[15] : op == 3'h5 ? e[31] : 1'b0);
        last[15:0] = e[15:0];
        if (op[0]) last[31:16] = e[31:16];
      end
      @(posedge CLK);
      #1 chk({mem_hi, mem_lo}, last);
    end
  endtask

  task hold(input once, output [7:0] delta);
    begin
      c = wr_cnt;
      @(posedge CLK);
      OP <= 3'h4; SRC_LO <= 16'h5; ONCE <= once; EXEC <= 1'b1;
      repeat (20) @(posedge CLK);
      EXEC <= 1'b0; ONCE <= 1'b0;
      repeat (4) @(posedge CLK);
      #1 delta = wr_cnt - c;
    end
  endtask

  initial begin
    #100000;
    err_count = err_count + 1;
    final_report;
  end

  initial begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    rd(8'h00, d); chk(d, 32'h1);
    rd(8'h0c, d); chk(d, 32'h0);
    rd(8'h18, d); chk(d, 32'h0);
    run(3'h0, 32'h1234);
    run(3'h0, 32'h0);
    run(3'h0, 32'h12a4);
    run(3'h1, 32'h12345678);
    run(3'h1, 32'h1f000001);
    run(3'h2, 32'h270f);
    run(3'h2, 32'h2710);
    run(3'h3, 32'h05f5e0ff);
    run(3'h3, 32'h05f5e100);
    run(3'h3, 32'h0);
    run(3'h4, 32'h1);
    run(3'h4, 32'h8000);
    run(3'h4, 32'h0);
    run(3'h5, 32'h1);
    run(3'h5, 32'h0);
    rd(8'h10, d); chk(d, last);
    rd(8'h04, d); chk(d, 32'h2);
    rd(8'h14, d); chk(d, 32'hf);
    rd(8'h08, d); chk(d, 32'h3);
    wr(8'h0c, 32'h1);
    run(3'h4, 32'h7);
    @(posedge CLK);
    #1 chk(IRQ, 1'b1);
    rd(8'h08, d); chk(d[0], 1'b1);
    @(posedge CLK);
    #1 chk(IRQ, 1'b0);
    wr(8'h0c, 32'h0);
    run(3'h4, 32'h9);
    repeat (2) @(posedge CLK);
    #1 chk(IRQ, 1'b0);
    hold(1'b1, c); chk(c, 8'h1);
    hold(1'b0, c); chk(c > 8'h2, 1'b1);
    wr(8'h00, 32'h0);
    hold(1'b0, c); chk(c, 8'h0);
    wr(8'h00, 32'h1);
    // An unused operation code must not start anything
    c = wr_cnt;
    @(posedge CLK);
    OP <= 3'h6;
    EXEC <= 1'b1;
    @(posedge CLK);
    EXEC <= 1'b0;
    #1 chk(BUSY, 1'b0);
    repeat (3) @(posedge CLK);
    #1 chk(wr_cnt, c);
    final_report;
  end
endmodule
